/* File: sag_chopper.sv */
// constant-current chopper and bridge switch drive for one winding
`timescale 1ns/1ps
module sag_chopper (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic osc_tick,
  input wire logic chop_start,
  input wire logic nf,
  input wire logic dir_fwd,
  output logic [3:0] sw
);
  typedef struct packed {
    sag_pkg::sag_chop_t mode;
    logic [3:0] fcnt;
    logic [3:0] sw;
  } sag_chp_t;

  sag_chp_t st, next_st;

  // switch order {upper one, upper two, lower one, lower two}
  function automatic logic [3:0] pattern(input sag_pkg::sag_chop_t m, input logic fwd);
    logic [3:0] p;
    p = 4'h0;
    unique case (m)
      sag_pkg::chop_off: p = 4'h0;
      sag_pkg::chop_charge: p = fwd ? 4'h9 : 4'h6;
      sag_pkg::chop_slow: p = 4'h3;
      sag_pkg::chop_fast: p = fwd ? 4'h6 : 4'h9;
    endcase
    return p;
  endfunction

  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.mode = sag_pkg::chop_off;
      next_st.fcnt = 4'h0;
    end else begin
      unique case (st.mode)
        sag_pkg::chop_off: begin
          if (chop_start) begin
            next_st.mode = sag_pkg::chop_charge;
          end
        end
        // charge may run past a period until the threshold is met
        sag_pkg::chop_charge: begin
          if (nf) begin
            next_st.mode = sag_pkg::chop_fast;
            next_st.fcnt = 4'h0;
          end
        end
        sag_pkg::chop_fast: begin
          if (chop_start) begin
            next_st.mode = sag_pkg::chop_charge;
          end else if (osc_tick) begin
            if (st.fcnt == 4'(sag_pkg::FAST_TICKS - 1)) begin
              next_st.mode = sag_pkg::chop_slow;
            end else begin
              next_st.fcnt = st.fcnt + 4'h1;
            end
          end
        end
        sag_pkg::chop_slow: begin
          if (chop_start) begin
            next_st.mode = sag_pkg::chop_charge;
          end
        end
      endcase
    end
    next_st.sw = pattern(next_st.mode, dir_fwd);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sw = st.sw;
endmodule

/* File: sag_ctrl.sv */
// anti-stall, fault flag, standby and chopping control with register slave
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sag_ctrl #(
  parameter int STEP_FREQ_LIMIT_SEL_CYC_HI = sag_pkg::STEP_FREQ_LIMIT_SEL_CYC0,
  parameter int STEP_FREQ_LIMIT_SEL_CYC_MID = sag_pkg::STEP_FREQ_LIMIT_SEL_CYC1,
  parameter int STEP_FREQ_LIMIT_SEL_CYC_LOW = sag_pkg::STEP_FREQ_LIMIT_SEL_CYC2
) (
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // configuration pins
  input wire logic antistall_enable,
  input wire logic bottom_limit_sel_lo,
  input wire logic [1:0] bottom_limit_sel_hi,
  input wire logic [1:0] boost_step_sel,
  input wire logic [1:0] step_freq_limit_sel,
  input wire logic stall_detect_threshold,
  input wire logic standby_n,
  input wire logic motor_supply,
  // analog detector outputs and step timing
  input wire logic thermal_fault,
  input wire logic overcurrent_fault,
  input wire logic load_open_fault,
  input wire logic load_rising,
  input wire logic step_clock,
  input wire logic [1:0] current_reached,
  input wire logic [1:0] phase_fwd,
  // open-drain flags
  input wire logic fault_flag_first_in,
  output logic fault_flag_first_out,
  output logic fault_flag_first_oe,
  input wire logic fault_flag_second_in,
  output logic fault_flag_second_out,
  output logic fault_flag_second_oe,
  // bridge and current setting
  output logic [1:0] upper_switch_one,
  output logic [1:0] upper_switch_two,
  output logic [1:0] lower_switch_one,
  output logic [1:0] lower_switch_two,
  output logic [6:0] current_pct,
  output logic ref_gain_tenth
);
  if (STEP_FREQ_LIMIT_SEL_CYC_HI < 1 || STEP_FREQ_LIMIT_SEL_CYC_MID > 65535 || STEP_FREQ_LIMIT_SEL_CYC_LOW > 65535) begin : g_bad_step_freq_limit_sel
    $error("frequency limit count out of range");
  end

  // ============================================================
  // state
  typedef struct packed {
    logic [1:0] th_s;
    logic [1:0] oc_s;
    logic [1:0] op_s;
    logic [1:0] sb_s;
    logic [1:0] sup_s;
    logic [1:0] ld_s;
    logic [1:0] stp_s;
    logic [1:0] thr_s;
    logic [1:0] nf_s1;
    logic [1:0] nf_s2;
    logic [1:0] dir_s1;
    logic [1:0] dir_s2;
    logic [1:0] fl_s1;
    logic [1:0] fl_s2;
    logic sup_q;
    logic stp_q;
    logic [3:0] osc_cnt;
    logic [3:0] chop_cnt;
    logic th_f;
    logic oc_f;
    logic op_f;
    logic [31:0] ctrl;
    logic [31:0] setup;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] per_cnt;
    logic slow;
    logic [6:0] cur;
    logic [3:0] boost_left;
  } sag_top_t;

  sag_top_t st, next_st;

  logic [7:0] pin_cfg;
  logic [7:0] cfg;
  logic osc_tick;
  logic chop_start;
  logic run;
  logic agc_active;
  logic [1:0] code;
  logic [6:0] bot;
  logic [15:0] lim;
  logic [2:0] res;
  logic sup_rise;
  logic req;
  logic [3:0] sw_ch [2];

  // ============================================================
  // configuration inputs
  sag_filter #(
    .W(8),
    .N(sag_pkg::FILT_TICKS)
  ) u_filt (
    .mclk(mclk),
    .rst(rst),
    .tick(osc_tick),
    .din({boost_step_sel, step_freq_limit_sel, bottom_limit_sel_hi, bottom_limit_sel_lo,
          antistall_enable}),
    .dout(pin_cfg)
  );

  // same field layout as the setup register
  assign cfg = st.ctrl[sag_pkg::CTRL_SERIAL] ? st.setup[7:0] : pin_cfg;

  // ============================================================
  // oscillator and chopping clock, stopped in standby
  assign run = st.sb_s[1] & st.sup_s[1] & ~(st.th_f | st.oc_f | st.op_f);
  assign osc_tick = st.sb_s[1] & (st.osc_cnt == 4'(sag_pkg::OSC_DIV - 1));
  assign chop_start = osc_tick & (st.chop_cnt == 4'(sag_pkg::CHOP_DIV - 1));

  // ============================================================
  // anti-stall settings
  assign bot = sag_pkg::bottom_pct(cfg[sag_pkg::SET_CLO], cfg[sag_pkg::SET_CHI +: 2]);
  assign res = (st.ctrl[sag_pkg::CTRL_RES +: 3] > sag_pkg::MAX_RES) ? sag_pkg::MAX_RES
             : st.ctrl[sag_pkg::CTRL_RES +: 3];

  always_comb begin
    lim = 16'(STEP_FREQ_LIMIT_SEL_CYC_LOW);
    unique case (cfg[sag_pkg::SET_STEP_FREQ_LIMIT_SEL +: 2])
      2'h0: lim = 16'(STEP_FREQ_LIMIT_SEL_CYC_HI);
      2'h1: lim = 16'(STEP_FREQ_LIMIT_SEL_CYC_MID);
      default: lim = 16'(STEP_FREQ_LIMIT_SEL_CYC_LOW);
    endcase
    lim = lim >> res;
  end

  // ground-short setting switches the frequency limit off
  assign agc_active = cfg[sag_pkg::SET_AGC]
                    & ((cfg[sag_pkg::SET_STEP_FREQ_LIMIT_SEL +: 2] == sag_pkg::LVL_GND) | ~st.slow);

  // ============================================================
  // fault coding, thermal beats overcurrent beats load open
  always_comb begin
    if (st.th_f) begin
      code = 2'h3;
    end else if (st.oc_f) begin
      code = 2'h2;
    end else if (st.op_f) begin
      code = 2'h1;
    end else begin
      code = 2'h0;
    end
  end

  assign sup_rise = st.sup_s[1] & ~st.sup_q;
  assign req = avs_read | avs_write;

  // ============================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.th_s = {st.th_s[0], thermal_fault};
    next_st.oc_s = {st.oc_s[0], overcurrent_fault};
    next_st.op_s = {st.op_s[0], load_open_fault};
    next_st.sb_s = {st.sb_s[0], standby_n};
    next_st.sup_s = {st.sup_s[0], motor_supply};
    next_st.ld_s = {st.ld_s[0], load_rising};
    next_st.stp_s = {st.stp_s[0], step_clock};
    next_st.thr_s = {st.thr_s[0], stall_detect_threshold};
    next_st.nf_s1 = current_reached;
    next_st.nf_s2 = st.nf_s1;
    next_st.dir_s1 = phase_fwd;
    next_st.dir_s2 = st.dir_s1;
    next_st.fl_s1 = {fault_flag_first_in, fault_flag_second_in};
    next_st.fl_s2 = st.fl_s1;
    next_st.sup_q = st.sup_s[1];
    next_st.stp_q = st.stp_s[1];

    // oscillator divider
    if (!st.sb_s[1]) begin
      next_st.osc_cnt = 4'h0;
      next_st.chop_cnt = 4'h0;
    end else if (osc_tick) begin
      next_st.osc_cnt = 4'h0;
      next_st.chop_cnt = st.chop_cnt + 4'h1;
    end else begin
      next_st.osc_cnt = st.osc_cnt + 4'h1;
    end

    // sticky faults; a fault still present at the clear wins
    if (!st.sb_s[1] || sup_rise) begin
      next_st.th_f = 1'b0;
      next_st.oc_f = 1'b0;
      next_st.op_f = 1'b0;
    end
    if (st.th_s[1]) begin
      next_st.th_f = 1'b1;
    end
    if (st.oc_s[1]) begin
      next_st.oc_f = 1'b1;
    end
    if (st.op_s[1]) begin
      next_st.op_f = 1'b1;
    end

    // step period measurement, saturating
    if (st.stp_s[1] && !st.stp_q) begin
      next_st.per_cnt = 16'h0000;
      next_st.slow = (st.per_cnt >= lim);
    end else begin
      if (st.per_cnt != 16'hFFFF) begin
        next_st.per_cnt = st.per_cnt + 16'h0001;
      end
      // no edge for longer than the limit means the clock is slow
      if (st.per_cnt >= lim) begin
        next_st.slow = 1'b1;
      end
    end

    // current level, one step per chopping period
    if (!agc_active) begin
      next_st.cur = sag_pkg::PCT_FULL;
      next_st.boost_left = sag_pkg::boost_steps(cfg[sag_pkg::SET_BST +: 2]);
    end else if (chop_start) begin
      if (st.ld_s[1]) begin
        if (st.boost_left != 4'h0 && st.cur < sag_pkg::PCT_FULL) begin
          next_st.cur = st.cur + 7'h01;
          next_st.boost_left = st.boost_left - 4'h1;
        end
      end else begin
        next_st.boost_left = sag_pkg::boost_steps(cfg[sag_pkg::SET_BST +: 2]);
        if (st.cur > bot) begin
          next_st.cur = st.cur - 7'h01;
        end else if (st.cur < bot) begin
          next_st.cur = st.cur + 7'h01;
        end
      end
    end

    // register slave, one wait state per access
    next_st.ack = req & ~st.ack;
    if (req && !st.ack && avs_read) begin
      unique case (avs_address)
        sag_pkg::REG_CTRL: next_st.rdata = {27'h0, st.ctrl[4:0]};
        sag_pkg::REG_SETUP: next_st.rdata = {24'h0, st.setup[7:0]};
        sag_pkg::REG_STATUS: next_st.rdata = {24'h0, st.fl_s2, st.thr_s[1], ~st.sb_s[1],
                                              st.slow, agc_active, code};
        sag_pkg::REG_LEVEL: next_st.rdata = {17'h0, bot, 1'b0, st.cur};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (st.ack && avs_write) begin
      if (avs_address == sag_pkg::REG_CTRL) begin
        next_st.ctrl = {27'h0, avs_writedata[4:0]};
      end
      if (avs_address == sag_pkg::REG_SETUP) begin
        next_st.setup = {24'h0, avs_writedata[7:0]};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= sag_pkg::CTRL_RST;
      st.setup <= sag_pkg::SETUP_RST;
      st.cur <= sag_pkg::PCT_FULL;
    end else begin
      st <= next_st;
    end
  end

  // ============================================================
  // bridge channels
  for (genvar i = 0; i < 2; i++) begin : g_ch
    sag_chopper u_chop (
      .mclk(mclk),
      .rst(rst),
      .run(run),
      .osc_tick(osc_tick),
      .chop_start(chop_start),
      .nf(st.nf_s2[i]),
      .dir_fwd(st.dir_s2[i]),
      .sw(sw_ch[i])
    );
    assign upper_switch_one[i] = sw_ch[i][3];
    assign upper_switch_two[i] = sw_ch[i][2];
    assign lower_switch_one[i] = sw_ch[i][1];
    assign lower_switch_two[i] = sw_ch[i][0];
  end

  // ============================================================
  // outputs
  assign avs_waitrequest = req & ~st.ack;
  assign avs_readdata = st.rdata;
  assign fault_flag_first_out = 1'b0;
  assign fault_flag_second_out = 1'b0;
  assign fault_flag_first_oe = code[1];
  assign fault_flag_second_oe = code[0];
  assign current_pct = st.cur;
  assign ref_gain_tenth = st.ctrl[sag_pkg::CTRL_GAIN];
endmodule

/* File: sag_ctrl_asserts.sv */
// concurrent checks on the ports of the anti-stall control block
`timescale 1ns/1ps
module sag_ctrl_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic standby_n,
  input wire logic motor_supply,
  input wire logic thermal_fault,
  input wire logic fault_flag_first_out,
  input wire logic fault_flag_first_oe,
  input wire logic fault_flag_second_out,
  input wire logic fault_flag_second_oe,
  input wire logic [1:0] upper_switch_one,
  input wire logic [1:0] upper_switch_two,
  input wire logic [1:0] lower_switch_one,
  input wire logic [1:0] lower_switch_two,
  input wire logic [6:0] current_pct,
  input wire logic ref_gain_tenth
);
  // ==========
  // helpers
  logic [3:0] clr_age;
  wire [3:0] sw_a = {upper_switch_one[0], upper_switch_two[0], lower_switch_one[0], lower_switch_two[0]};
  wire [3:0] sw_b = {upper_switch_one[1], upper_switch_two[1], lower_switch_one[1], lower_switch_two[1]};
  wire any_flag = fault_flag_first_oe || fault_flag_second_oe;
  wire ctrl_wr = avs_write && !avs_waitrequest && avs_address == 4'h0;
  // age since a clear source; a supply dip also restarts it, its rise clears
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clr_age <= 4'h0;
    end else if (!standby_n || !motor_supply) begin
      clr_age <= 4'h0;
    end else if (clr_age != 4'hF) begin
      clr_age <= clr_age + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========
  // properties
  AST_ONE_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus request not answered after one wait state");
  AST_UNMAPPED_ZERO: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |->
    avs_readdata == 32'h0) else $error("unmapped read returned data");
  AST_FLAG_DRIVE_LOW: assert property (!fault_flag_first_out && !fault_flag_second_out)
    else $error("flag pin driven high");
  AST_THERMAL_CODE: assert property (thermal_fault [*8] |-> fault_flag_first_oe && fault_flag_second_oe)
    else $error("thermal fault not shown on both flags");
  AST_FAULT_HOLD: assert property (any_flag && clr_age == 4'hF |=> any_flag)
    else $error("fault flag released without a clear");
  AST_STANDBY_OFF: assert property (!standby_n [*4] |-> sw_a == 4'h0 && sw_b == 4'h0)
    else $error("bridge active in standby");
  AST_FAULT_OFF: assert property (any_flag [*2] |-> sw_a == 4'h0 && sw_b == 4'h0)
    else $error("bridge active with a latched fault");
  AST_LEGAL_SWITCH: assert property (sw_a inside {4'h0, 4'h9, 4'h6, 4'h3} &&
    sw_b inside {4'h0, 4'h9, 4'h6, 4'h3}) else $error("illegal bridge switch pattern");
  AST_GRADUAL: assert property ($changed(current_pct) && current_pct != 7'h64 |->
    current_pct == $past(current_pct) + 7'h1 || current_pct + 7'h1 == $past(current_pct))
    else $error("current level jumped");
  AST_GAIN_BY_WRITE: assert property ($changed(ref_gain_tenth) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("gain select changed without a control write");
  cover property (fault_flag_first_oe && fault_flag_second_oe);
  cover property (sw_a == 4'h6);
  cover property (current_pct == 7'h3E);
endmodule
bind sag_ctrl sag_ctrl_asserts sag_ctrl_asserts_inst (.*);

/* File: sag_filter.sv */
// level filter on the oscillator tick for configuration inputs
`timescale 1ns/1ps
module sag_filter #(
  parameter int W = 8,
  parameter int N = sag_pkg::FILT_TICKS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  if (N < 1 || N > 255) begin : g_bad_n
    $error("filter length out of range");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] cand;
    logic [7:0] cnt;
    logic [W-1:0] q;
  } sag_filt_t;

  sag_filt_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    // any change restarts the stability count
    if (st.s2 != st.cand) begin
      next_st.cand = st.s2;
      next_st.cnt = 8'h00;
    end else if (tick) begin
      // the first tick closes a partial interval, so it never counts
      if (st.cnt == 8'(N)) begin
        next_st.q = st.cand;
      end else begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q;
endmodule

/* File: sag_motor_model.sv */
// behavioural load of two motor windings seen through the bridge switches
`timescale 1ns/1ps
module sag_motor_model #(
  parameter int LIMIT = 20
) (
  input wire logic mclk,
  input wire logic heavy,
  input wire logic [1:0] phase_fwd,
  input wire logic [1:0] upper_switch_one,
  input wire logic [1:0] upper_switch_two,
  input wire logic [1:0] lower_switch_one,
  input wire logic [1:0] lower_switch_two,
  output logic [1:0] current_reached
);
  // ==========
  // winding current magnitude per channel
  int mag [2];
  logic [1:0] cyc = 2'h0;
  logic [3:0] s;
  initial current_reached = 2'h0;
  always @(posedge mclk) begin
    cyc <= cyc + 2'h1;
    for (int c = 0; c < 2; c++) begin
      s = {upper_switch_one[c], upper_switch_two[c], lower_switch_one[c], lower_switch_two[c]};
      // heavy load rises at half rate: the slow answer
      if (s == (phase_fwd[c] ? 4'h9 : 4'h6)) begin
        mag[c] = mag[c] + (heavy ? int'(cyc[0]) : 1);
      end else if (s == (phase_fwd[c] ? 4'h6 : 4'h9)) begin
        mag[c] = mag[c] > 2 ? mag[c] - 2 : 0;
      end else if (s == 4'h3 && cyc == 2'h0 && mag[c] > 0) begin
        mag[c] = mag[c] - 1;
      end else if (s == 4'h0) begin
        mag[c] = 0;
      end
      current_reached[c] <= mag[c] >= LIMIT;
    end
  end
endmodule

/* File: sag_pkg.sv */
// shared constants and types of the anti-stall stepper control block
// ============================================================
// Contract
// - anti-stall gain control follows the enable input level.
// - enabled, current drops gradually with load; disabled, it stays at reference.
// - enable, bottom-limit, boost and frequency inputs pass a 0.625 us filter.
// - first bottom select is two-level, second bottom select four-level.
// - bottom limit 60/55/50/45 % when first select low, 80/75/70/65 % when high.
// - boost under rising load limited to 5, 7, 9 or 11 steps.
// - anti-stall suppressed below 675/450/225 Hz at full step; ground short disables.
// - frequency threshold doubles per halving of step size, to 1/32 step.
// - pulled-down threshold input gives the standard detection sensitivity; the code only reports the input in the status register.
// - two open-drain flags code normal, load open, overcurrent, thermal.
// - flags released in normal use, pulled low once a fault is seen.
// - fault held until supply is reapplied or standby is entered.
// - standby input low stops oscillator and bridge; high runs normally.
// - forward direction switch pattern for charge, slow and fast decay.
// - reverse direction switch pattern for charge, slow and fast decay.
// - bridge moves among charge, slow and fast decay on the oscillator clock.
// - chopping frequency is the oscillator frequency divided by sixteen.
// - reference gain one fifth when gain select low, one tenth when high.
// - in serial mode the settings come from the setup register, not pins.
package sag_pkg;
  // ============================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int OSC_DIV = 8;
  localparam int OSC_NS = OSC_DIV * CLK_NS;
  localparam int FILT_NS = 625;
  localparam int FILT_TICKS = (FILT_NS + OSC_NS - 1) / OSC_NS;
  localparam int CHOP_DIV = 16;
  localparam int FAST_TICKS = 6;
  localparam int STEP_FREQ_LIMIT_SEL_HZ0 = 675;
  localparam int STEP_FREQ_LIMIT_SEL_HZ1 = 450;
  localparam int STEP_FREQ_LIMIT_SEL_HZ2 = 225;
  localparam int STEP_FREQ_LIMIT_SEL_CYC0 = (CLK_HZ + STEP_FREQ_LIMIT_SEL_HZ0 - 1) / STEP_FREQ_LIMIT_SEL_HZ0;
  localparam int STEP_FREQ_LIMIT_SEL_CYC1 = (CLK_HZ + STEP_FREQ_LIMIT_SEL_HZ1 - 1) / STEP_FREQ_LIMIT_SEL_HZ1;
  localparam int STEP_FREQ_LIMIT_SEL_CYC2 = (CLK_HZ + STEP_FREQ_LIMIT_SEL_HZ2 - 1) / STEP_FREQ_LIMIT_SEL_HZ2;
  localparam logic [2:0] MAX_RES = 3'h5;
  localparam logic [1:0] LVL_GND = 2'h3;
  // ============================================================
  // current levels in percent, and the boost step base
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] BOT_BASE_LO = 7'h3C;
  localparam logic [6:0] BOT_BASE_HI = 7'h50;
  localparam logic [3:0] BOOST_BASE = 4'h5;
  // ============================================================
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SETUP = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_LEVEL = 4'hC;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SETUP_RST = 32'h0000_0000;
  localparam int CTRL_SERIAL = 0;
  localparam int CTRL_GAIN = 1;
  localparam int CTRL_RES = 2;
  localparam int SET_AGC = 0;
  localparam int SET_CLO = 1;
  localparam int SET_CHI = 2;
  localparam int SET_STEP_FREQ_LIMIT_SEL = 4;
  localparam int SET_BST = 6;
  localparam int LVL_BOT = 8;
  // ============================================================
  typedef enum logic [1:0] {chop_off, chop_charge, chop_fast, chop_slow} sag_chop_t;

  // four-level code: 0 supply short, 1 pull-up, 2 pull-down, 3 ground short
  function automatic logic [6:0] bottom_pct(input logic lo, input logic [1:0] hi);
    logic [6:0] base;
    base = lo ? BOT_BASE_HI : BOT_BASE_LO;
    return base - 7'(5 * hi);
  endfunction

  function automatic logic [3:0] boost_steps(input logic [1:0] code);
    return BOOST_BASE + {1'b0, code, 1'b0};
  endfunction
endpackage

/* File: sag_testbench.sv */
// self-checking bench of the anti-stall control block
`timescale 1ns/1ps
module testbench;
  // ==========
  // signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic antistall_enable = 1'b0;
  logic bottom_limit_sel_lo = 1'b0;
  logic [1:0] bottom_limit_sel_hi = 2'h0;
  logic [1:0] boost_step_sel = 2'h0;
  logic [1:0] step_freq_limit_sel = 2'h3;
  logic stall_detect_threshold = 1'b1;
  logic standby_n = 1'b1;
  logic motor_supply = 1'b1;
  logic thermal_fault = 1'b0;
  logic overcurrent_fault = 1'b0;
  logic load_open_fault = 1'b0;
  logic load_rising = 1'b0;
  logic step_clock = 1'b0;
  logic [1:0] current_reached;
  logic [1:0] phase_fwd = 2'h1;
  logic heavy = 1'b0;
  logic fault_flag_first_out, fault_flag_first_oe, fault_flag_second_out, fault_flag_second_oe;
  logic [1:0] upper_switch_one, upper_switch_two, lower_switch_one, lower_switch_two;
  logic [6:0] current_pct;
  logic ref_gain_tenth;
  logic [31:0] q;
  int step_half = 500;
  int miscompares = 0;
  int n_compared = 0;
  // board pull-ups on the open-drain flags
  wire fault_flag_first_in = fault_flag_first_oe ? fault_flag_first_out : 1'b1;
  wire fault_flag_second_in = fault_flag_second_oe ? fault_flag_second_out : 1'b1;
  wire [3:0] sw_a = {upper_switch_one[0], upper_switch_two[0], lower_switch_one[0], lower_switch_two[0]};
  wire [31:0] flags = {30'h0, fault_flag_first_in, fault_flag_second_in};
  wire [31:0] bridge = {24'h0, upper_switch_one, upper_switch_two, lower_switch_one, lower_switch_two};
  // small step-period limits keep the run short
  sag_ctrl #(.STEP_FREQ_LIMIT_SEL_CYC_HI(400), .STEP_FREQ_LIMIT_SEL_CYC_MID(600), .STEP_FREQ_LIMIT_SEL_CYC_LOW(1200)) sag_ctrl_inst (.*);
  sag_motor_model sag_motor_model_inst (.*);
  always #50 mclk = ~mclk;
  always begin
    repeat (step_half) @(posedge mclk);
    step_clock <= ~step_clock;
  end
  // ==========
  // shared tasks
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", w, e, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40) begin
      check("bus answer", 32'h0, 32'h1);
      test_done();
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
    bus(1'b0, a, 32'h0);
    check(w, q & m, e);
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    rdchk(4'h0, 32'hFFFFFFFF, sag_pkg::CTRL_RST, "ctrl reset");
    rdchk(4'h4, 32'hFFFFFFFF, sag_pkg::SETUP_RST, "setup reset");
    rdchk(4'h8, 32'hF7, 32'hE0, "status idle");
    bus(1'b1, 4'h2, 32'h3);
    rdchk(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped read");
    rdchk(4'h0, 32'hFFFFFFFF, 32'h0, "ctrl untouched");
    bus(1'b1, 4'h0, 32'h2);
    settle(2);
    check("gain tenth", 32'(ref_gain_tenth), 32'h1);
    bus(1'b1, 4'h0, 32'h0);
    settle(2);
    check("gain fifth", 32'(ref_gain_tenth), 32'h0);
  endtask
  task automatic t_bottom();
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      bottom_limit_sel_lo <= i[2];
      bottom_limit_sel_hi <= i[1:0];
      repeat (30) @(posedge mclk);
      rdchk(4'hC, 32'h7F00, {17'h0, 7'((i[2] ? 80 : 60) - 5 * i[1:0]), 8'h0}, "bottom limit");
    end
  endtask
  task automatic t_bridge();
    logic [3:0] chg, p;
    logic [2:0] seen;
    int t0, t1;
    for (int d = 0; d < 4; d++) begin
      @(posedge mclk);
      phase_fwd <= d[0] ? 2'h2 : 2'h1;
      heavy <= d[1];
      chg = d[0] ? 4'h6 : 4'h9;
      seen = 3'h0;
      t0 = 0;
      t1 = 0;
      p = 4'h0;
      settle(300);
      for (int k = 0; k < 400; k++) begin
        @(negedge mclk);
        if (sw_a == chg && p != chg) begin
          t0 = t1;
          t1 = k;
        end
        seen = seen | {sw_a == chg, sw_a == ~chg, sw_a == 4'h3};
        p = sw_a;
      end
      check("bridge states", 32'(seen), 32'h7);
      check("chop period", t1 - t0, 32'h80);
    end
    @(posedge mclk);
    standby_n <= 1'b0;
    settle(6);
    check("standby bridge", bridge, 32'h0);
    @(posedge mclk);
    standby_n <= 1'b1;
  endtask
  task automatic t_agc();
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b1, 4'h4, 32'h75);
    settle(6400);
    check("agc bottom", 32'(current_pct), 32'h37);
    @(posedge mclk);
    load_rising <= 1'b1;
    settle(1280);
    check("agc boost", 32'(current_pct), 32'h3E);
    bus(1'b1, 4'h4, 32'h74);
    settle(300);
    check("agc off", 32'(current_pct), 32'h64);
    @(posedge mclk);
    load_rising <= 1'b0;
    step_half <= 150;
    bus(1'b1, 4'h4, 32'h45);
    settle(3000);
    rdchk(4'h8, 32'hC, 32'h4, "fast steps allow agc");
    bus(1'b1, 4'h0, 32'h5);
    settle(3000);
    rdchk(4'h8, 32'hC, 32'h8, "limit scaled by resolution");
    check("agc held off", 32'(current_pct), 32'h64);
    bus(1'b1, 4'h0, 32'h0);
  endtask
  task automatic t_fault();
    logic [1:0] code;
    for (int f = 0; f < 3; f++) begin
      code = 2'(3 - f);
      @(posedge mclk);
      thermal_fault <= f == 0;
      overcurrent_fault <= f == 1;
      load_open_fault <= f == 2;
      repeat (10) @(posedge mclk);
      thermal_fault <= 1'b0;
      overcurrent_fault <= 1'b0;
      load_open_fault <= 1'b0;
      settle(60);
      check("flag pins", flags, {30'h0, ~code});
      check("bridge off", bridge, 32'h0);
      rdchk(4'h8, 32'h3, {30'h0, code}, "fault code");
      standby_n <= f != 1;
      motor_supply <= f == 1;
      repeat (20) @(posedge mclk);
      standby_n <= 1'b1;
      motor_supply <= 1'b1;
      settle(20);
      check("flags released", flags, 32'h3);
    end
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_bottom();
    t_bridge();
    t_agc();
    t_fault();
    test_done();
  end
endmodule
